//--- src/slc_map.vh
// register map and reset values of the serial lane crossbar configuration
// assumes inclusion by slc_top.v only
`ifndef SLC_MAP_VH
`define SLC_MAP_VH
// printed offsets are not all multiples of four: they are indexes
`define SLC_IDX_MAP_1_0 12'h5B2
`define SLC_IDX_MAP_3_2 12'h5B3
`define SLC_IDX_MAP_5_4 12'h5B5
`define SLC_IDX_MAP_7_6 12'h5B6
`define SLC_IDX_INVERT 12'h5BF
// selector fields
`define SLC_SEL_LO_MSB 2
`define SLC_SEL_LO_LSB 0
`define SLC_SEL_HI_MSB 6
`define SLC_SEL_HI_LSB 4
// reset values of whole registers
`define SLC_RST_MAP_1_0 8'h10
`define SLC_RST_MAP_3_2 8'h32
`define SLC_RST_MAP_5_4 8'h54
`define SLC_RST_MAP_7_6 8'h76
`define SLC_RST_INVERT 8'h00
// writable bits of a lane map register; bits 7 and 3 are reserved
`define SLC_MAP_WMASK 8'h77
// selector width and lane count
`define SLC_SEL_W 3
`define SLC_NUM_LANES 8
// word offset bits of an accepted address
`define SLC_WORD_OFS 2'h0
// zero padding above the read byte
`define SLC_RD_PAD 24'h00_0000
// reset value of each selector: identity map
`define SLC_RST_SEL_0 3'h0
`define SLC_RST_SEL_1 3'h1
`define SLC_RST_SEL_2 3'h2
`define SLC_RST_SEL_3 3'h3
`define SLC_RST_SEL_4 3'h4
`define SLC_RST_SEL_5 3'h5
`define SLC_RST_SEL_6 3'h6
`define SLC_RST_SEL_7 3'h7
`endif

//--- src/slc_top.v
// serial lane crossbar configuration: apb register slave plus lane crossbar
// assumes an apb master on REF_CLK_I and lane data from the same clock
// assumes the far-side receiver samples the lanes on the same clock
`include "slc_map.vh"
`default_nettype none

module slc_top #(
  parameter LANE_W = 8,
  parameter ADDR_W = 14
) (
  // clock and reset
  input wire REF_CLK_I,
  input wire SRST_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [ADDR_W-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // logical lane data in, physical lane data out
  input wire [8*LANE_W-1:0] LOGICAL_LANE_I,
  output reg [8*LANE_W-1:0] SERIAL_LANE_OUTPUT_O
);

  // ************************************************************
  // selector and invert storage
  // ************************************************************
  reg [`SLC_SEL_W-1:0] sel_0;
  reg [`SLC_SEL_W-1:0] sel_1;
  reg [`SLC_SEL_W-1:0] sel_2;
  reg [`SLC_SEL_W-1:0] sel_3;
  reg [`SLC_SEL_W-1:0] sel_4;
  reg [`SLC_SEL_W-1:0] sel_5;
  reg [`SLC_SEL_W-1:0] sel_6;
  reg [`SLC_SEL_W-1:0] sel_7;
  reg [7:0] invert;

  reg [`SLC_SEL_W-1:0] next_sel_0;
  reg [`SLC_SEL_W-1:0] next_sel_1;
  reg [`SLC_SEL_W-1:0] next_sel_2;
  reg [`SLC_SEL_W-1:0] next_sel_3;
  reg [`SLC_SEL_W-1:0] next_sel_4;
  reg [`SLC_SEL_W-1:0] next_sel_5;
  reg [`SLC_SEL_W-1:0] next_sel_6;
  reg [`SLC_SEL_W-1:0] next_sel_7;
  reg [7:0] next_invert;

  // ************************************************************
  // decode functions
  // ************************************************************
  // true for the five implemented word indexes only
  function hit;
    input [ADDR_W-3:0] a;
    begin
      case (a)
        `SLC_IDX_MAP_1_0: hit = 1'h1;
        `SLC_IDX_MAP_3_2: hit = 1'h1;
        `SLC_IDX_MAP_5_4: hit = 1'h1;
        `SLC_IDX_MAP_7_6: hit = 1'h1;
        `SLC_IDX_INVERT: hit = 1'h1;
        default: hit = 1'h0;
      endcase
    end
  endfunction

  // low selector field of a written byte
  function [`SLC_SEL_W-1:0] lo_field;
    input [7:0] d;
    begin
      lo_field = d[`SLC_SEL_LO_MSB:`SLC_SEL_LO_LSB];
    end
  endfunction

  // high selector field; bits 7 and 3 are reserved and never stored
  function [`SLC_SEL_W-1:0] hi_field;
    input [7:0] d;
    begin
      hi_field = d[`SLC_SEL_HI_MSB:`SLC_SEL_HI_LSB];
    end
  endfunction

  // two selectors packed as they read back, reserved bits as zero
  function [7:0] pack;
    input [`SLC_SEL_W-1:0] hi;
    input [`SLC_SEL_W-1:0] lo;
    begin
      pack = {1'h0, hi, 1'h0, lo};
    end
  endfunction

  // read-back mux; unimplemented indexes read as zero
  function [7:0] rd_byte;
    input [ADDR_W-3:0] a;
    begin
      case (a)
        `SLC_IDX_MAP_1_0: rd_byte = pack(sel_1, sel_0);
        `SLC_IDX_MAP_3_2: rd_byte = pack(sel_3, sel_2);
        `SLC_IDX_MAP_5_4: rd_byte = pack(sel_5, sel_4);
        `SLC_IDX_MAP_7_6: rd_byte = pack(sel_7, sel_6);
        `SLC_IDX_INVERT: rd_byte = invert;
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  // ************************************************************
  // apb decode
  // ************************************************************
  reg next_pready;
  reg next_pslverr;
  reg [31:0] next_prdata;
  wire [ADDR_W-3:0] idx;
  wire aligned;
  wire access;
  wire ok;
  wire rd;
  wire wr;
  wire [7:0] wbyte;

  assign idx = PADDR_I[ADDR_W-1:2];
  assign aligned = (PADDR_I[1:0] == `SLC_WORD_OFS);
  // take the request in the first access cycle only; the registered
  // ready that follows keeps the same transfer from being taken twice
  assign access = PSEL_I & PENABLE_I & ~PREADY_O;
  assign ok = aligned & hit(idx);
  assign rd = access & ~PWRITE_I & ok;
  assign wr = access & PWRITE_I & ok;
  assign wbyte = PWDATA_I[7:0];

  // ************************************************************
  // write strobes
  // ************************************************************
  // one strobe per implemented register
  wire wr_map_1_0;
  wire wr_map_3_2;
  wire wr_map_5_4;
  wire wr_map_7_6;
  wire wr_invert;

  assign wr_map_1_0 = wr & (idx == `SLC_IDX_MAP_1_0);
  assign wr_map_3_2 = wr & (idx == `SLC_IDX_MAP_3_2);
  assign wr_map_5_4 = wr & (idx == `SLC_IDX_MAP_5_4);
  assign wr_map_7_6 = wr & (idx == `SLC_IDX_MAP_7_6);
  assign wr_invert = wr & (idx == `SLC_IDX_INVERT);

  // ************************************************************
  // selector next values
  // ************************************************************
  always @* begin
    next_sel_0 = sel_0;
    next_sel_1 = sel_1;
    next_sel_2 = sel_2;
    next_sel_3 = sel_3;
    next_sel_4 = sel_4;
    next_sel_5 = sel_5;
    next_sel_6 = sel_6;
    next_sel_7 = sel_7;
    if (wr_map_1_0) begin
      next_sel_0 = lo_field(wbyte);
      next_sel_1 = hi_field(wbyte);
    end
    if (wr_map_3_2) begin
      next_sel_2 = lo_field(wbyte);
      next_sel_3 = hi_field(wbyte);
    end
    if (wr_map_5_4) begin
      next_sel_4 = lo_field(wbyte);
      next_sel_5 = hi_field(wbyte);
    end
    if (wr_map_7_6) begin
      next_sel_6 = lo_field(wbyte);
      next_sel_7 = hi_field(wbyte);
    end
  end

  // ************************************************************
  // invert next value
  // ************************************************************
  always @* begin
    next_invert = invert;
    if (wr_invert) begin
      next_invert = wbyte;
    end
  end

  // ************************************************************
  // apb response
  // ************************************************************
  always @* begin
    next_pready = access;
    // unmapped or unaligned: write dropped, read zero, error flagged
    next_pslverr = access & ~ok;
  end

  // ************************************************************
  // read data
  // ************************************************************
  // read data stands only in the ready cycle, zero otherwise
  always @* begin
    next_prdata = 32'h0000_0000;
    if (rd) begin
      next_prdata = {`SLC_RD_PAD, rd_byte(idx)};
    end
  end

  // ************************************************************
  // register stage
  // ************************************************************
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sel_0 <= `SLC_RST_SEL_0;
      sel_1 <= `SLC_RST_SEL_1;
      sel_2 <= `SLC_RST_SEL_2;
      sel_3 <= `SLC_RST_SEL_3;
      sel_4 <= `SLC_RST_SEL_4;
      sel_5 <= `SLC_RST_SEL_5;
      sel_6 <= `SLC_RST_SEL_6;
      sel_7 <= `SLC_RST_SEL_7;
      invert <= `SLC_RST_INVERT;
    end else begin
      sel_0 <= next_sel_0;
      sel_1 <= next_sel_1;
      sel_2 <= next_sel_2;
      sel_3 <= next_sel_3;
      sel_4 <= next_sel_4;
      sel_5 <= next_sel_5;
      sel_6 <= next_sel_6;
      sel_7 <= next_sel_7;
      invert <= next_invert;
    end
  end

  // status outputs held low through reset
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      PREADY_O <= 1'h0;
      PSLVERR_O <= 1'h0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= next_pready;
      PSLVERR_O <= next_pslverr;
      PRDATA_O <= next_prdata;
    end
  end

  // ************************************************************
  // crossbar
  // ************************************************************
  wire [`SLC_NUM_LANES*`SLC_SEL_W-1:0] sel_all;
  wire [`SLC_NUM_LANES*LANE_W-1:0] crossed;
  assign sel_all = {sel_7, sel_6, sel_5, sel_4, sel_3, sel_2, sel_1, sel_0};

  // duplicate selections are software's concern; hardware just copies
  genvar g;
  generate
    for (g = 0; g < `SLC_NUM_LANES; g = g + 1) begin : lane
      wire [`SLC_SEL_W-1:0] sel;
      assign sel = sel_all[g*`SLC_SEL_W +: `SLC_SEL_W];
      assign crossed[g*LANE_W +: LANE_W] =
        LOGICAL_LANE_I[sel*LANE_W +: LANE_W];
    end
  endgenerate

  // ************************************************************
  // polarity
  // ************************************************************
  // inversion follows the crossbar, so bit p always flips physical lane p
  wire [`SLC_NUM_LANES*LANE_W-1:0] next_lanes;

  generate
    for (g = 0; g < `SLC_NUM_LANES; g = g + 1) begin : flip
      assign next_lanes[g*LANE_W +: LANE_W] =
        crossed[g*LANE_W +: LANE_W] ^ {LANE_W{invert[g]}};
    end
  endgenerate

  // ************************************************************
  // output register
  // ************************************************************
  // one stage so every lane leaves straight from a flip-flop; lanes
  // lag the logical input by one clock and any selector write by two
  always @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      SERIAL_LANE_OUTPUT_O <= {8*LANE_W{1'h0}};
    end else begin
      SERIAL_LANE_OUTPUT_O <= next_lanes;
    end
  end

endmodule

`default_nettype wire

//--- tb/serial_lane_crossbar_config_tb.sv
// register and crossbar bench; assumes slc_top, slc_rx and checker
`default_nettype none
module serial_lane_crossbar_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, pready, perr;
  logic [13:0] addr = 14'h0;
  logic [31:0] wd = 32'h0, prdata;
  logic [63:0] lin = 64'h0706050403020100, lout, rx;
  logic [11:0] idx [5] = '{12'h5B2, 12'h5B3, 12'h5B5, 12'h5B6, 12'h5BF};
  logic [7:0] rv [5] = '{8'h10, 8'h32, 8'h54, 8'h76, 8'h00};
  logic [7:0] nv [4] = '{8'h67, 8'h45, 8'h23, 8'h01};
  int failures = 0, checked = 0;
  slc_top DUT (.REF_CLK_I(clk), .SRST_I(rst), .PSEL_I(sel), .PENABLE_I(en),
    .PWRITE_I(wr), .PADDR_I(addr), .PWDATA_I(wd), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(perr), .LOGICAL_LANE_I(lin),
    .SERIAL_LANE_OUTPUT_O(lout));
  slc_rx RX (.clk_i(clk), .lane_i(lout), .rx_o(rx));
  initial forever #12.5 clk = ~clk;
  task automatic check(string n, logic [63:0] e, logic [63:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // reserved bits 7 and 3 must read back zero even after writing ones
  task automatic apb(logic w, logic [11:0] i, logic [7:0] d,
                     logic [7:0] e, logic er = 1'b0);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    addr <= {i, 2'h0};
    wd <= {24'h0, d};
    @(posedge clk) en <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) check("read data", {56'h0, e}, {32'h0, prdata});
    check("slave error", {63'h0, er}, {63'h0, perr});
    sel <= 1'b0;
    en <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset lanes", lin, lout);
    for (int k = 0; k < 5; k++) begin
      apb(0, idx[k], 0, rv[k]);
    end
    for (int k = 0; k < 4; k++) begin
      apb(1, idx[k], 8'hFF, 0);
      apb(0, idx[k], 0, 8'h77);
      apb(1, idx[k], nv[k], 0);
    end
    apb(1, 12'h5BF, 8'h01, 0);
    apb(0, 12'h5BF, 0, 8'h01);
    repeat (3) @(posedge clk);
    check("lanes", 64'h00010203040506F8, rx);
    check("lane outputs", 64'h00010203040506F8, lout);
    apb(0, 12'h5B4, 0, 0, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, idx[3], 0, rv[3]);
    check("lanes after reset", lin, lout);
    wrap_up();
  end
endmodule
`default_nettype wire

//--- tb/slc_chk_props.sv
// apb and lane timing checks; assumes binding onto slc_top
`default_nettype none
module slc_chk #(parameter LANE_W = 8) (
  input wire logic REF_CLK_I, SRST_I, PSEL_I, PENABLE_I,
  input wire logic PREADY_O, PSLVERR_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic [8*LANE_W-1:0] LOGICAL_LANE_I, SERIAL_LANE_OUTPUT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK_I); endclocking
  // first access cycle of a transfer, the one the slave takes
  sequence s_take;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  chk_ready_pulse: assert property (disable iff (SRST_I)
    PREADY_O |=> !PREADY_O) else $error("ready held too long");
  chk_ready_after: assert property (disable iff (SRST_I)
    s_take |=> PREADY_O) else $error("no ready");
  chk_no_spurious: assert property (disable iff (SRST_I)
    !PENABLE_I |=> !PREADY_O) else $error("ready without access");
  chk_err_ready: assert property (disable iff (SRST_I)
    PSLVERR_O |-> PREADY_O) else $error("error without ready");
  chk_rdata_idle: assert property (disable iff (SRST_I)
    !PREADY_O |-> PRDATA_O == 32'h0) else $error("read data outside ready");
  chk_rdata_upper: assert property (disable iff (SRST_I)
    PREADY_O |-> PRDATA_O[31:8] == 24'h0) else $error("upper bits set");
  chk_reset_map: assert property (
    $fell(SRST_I) |=> SERIAL_LANE_OUTPUT_O == $past(LOGICAL_LANE_I))
    else $error("lanes not identity after reset");
endmodule
bind slc_top slc_chk #(.LANE_W(LANE_W)) chk (.REF_CLK_I, .SRST_I, .PSEL_I,
  .PENABLE_I, .PREADY_O, .PSLVERR_O, .PRDATA_O, .LOGICAL_LANE_I,
  .SERIAL_LANE_OUTPUT_O);
`default_nettype wire

//--- tb/slc_rx_model.sv
// far-side receiver model; assumes lanes registered on the design clock
`default_nettype none
module slc_rx (
  input wire logic clk_i,
  input wire logic [63:0] lane_i,
  output logic [63:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a receiver simply captures every lane each word clock
  always_ff @(posedge clk_i) rx_o <= lane_i;
endmodule
`default_nettype wire
